// >>> flash_pkg_array.sv
// Shared constants and the byte-wide flash array storage.
package flash_pkg;
  localparam logic [15:0] FLASH_BYTES  = 16'h3000;
  localparam logic [15:0] SECTOR_BYTES = 16'h1000;
  localparam logic [15:0] FLASH_BASE   = 16'(17'h1_0000 - 17'(FLASH_BYTES));
  localparam logic [15:0] SEC0_BASE    = 16'hF000;
  localparam logic [15:0] SEC1_BASE    = 16'hE000;
  localparam logic [15:0] ADDR_TOP     = 16'hFFFF;
  localparam int          MEM_AW       = 14;
  localparam logic [1:0]  SECTOR_COUNT =
    (FLASH_BYTES <= 16'h1000) ? 2'h1 :
    (FLASH_BYTES <= 16'h2000) ? 2'h2 : 2'h3;
  localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
  localparam int          OPT_LOCK_BIT = 0;
  localparam int          OPT_LVS_BIT  = 1;
  localparam logic [7:0]  OPTION_INIT  = 8'h02;
  localparam logic [7:0]  GUARD_KEY1   = 8'h56;
  localparam logic [7:0]  GUARD_KEY2   = 8'hAE;
  localparam int          FRAME_BITS   = 27;
  localparam logic [4:0]  FRAME_LAST   = 5'h1A;
  localparam int          OP_LSB       = 24;
  localparam int          ADDR_LSB     = 8;
  localparam logic [3:0]  RESP_BITS    = 4'h9;
  localparam logic [1:0]  STRAP_WAIT   = 2'h3;
  localparam logic [2:0]  OP_READ      = 3'h0;
  localparam logic [2:0]  OP_PROG      = 3'h1;
  localparam logic [2:0]  OP_ERASE_SEC = 3'h2;
  localparam logic [2:0]  OP_ERASE_ALL = 3'h3;
  localparam logic [2:0]  OP_OPTION    = 3'h4;
endpackage

`timescale 1ns/1ns
module flash_array (
  input  wire logic                         clk_i,
  input  wire logic                         we_i,
  input  wire logic [flash_pkg::MEM_AW-1:0] addr_i,
  input  wire logic [7:0]                   wdata_i,
  output logic      [7:0]                   rdata_o
);
  logic [7:0] mem [0:int'(flash_pkg::FLASH_BYTES)-1];

  // Read data is registered; the array itself has no reset.
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule

// >>> flash_sector_access_control.sv
// Sectored flash access, protection and in-circuit link controller.
// Contract
// - Erase whole block or sector, program bytes.
// - Sector erase leaves other sectors untouched.
// - Tool and in-circuit modes access everything.
// - Application mode protects sector 0 and options.
// - Sector count follows flash size.
// - Sectors 0,1 are top 4K blocks.
// - Read-out lock blocks external memory reads.
// - Removing lock erases everything first.
// - One option bit holds the lock.
// - Lock disables the low-voltage supervisor.
// - Link uses clock, data, select, reset pins.
// - Attached tool owns link clock and data.
// - Key sequence guards program and erase; only app requests need it, link frames do not.
// - External select enters in-circuit mode.
`timescale 1ns/1ns
module flash_sector_access_control (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        app_req_i,
  input  wire logic [2:0]  app_op_i,
  input  wire logic [15:0] app_addr_i,
  input  wire logic [7:0]  app_wdata_i,
  input  wire logic        app_key_wr_i,
  input  wire logic [7:0]  app_key_i,
  input  wire logic        tool_insert_mode_i,
  input  wire logic        prog_link_clock_i,
  input  wire logic        prog_link_data_i,
  input  wire logic        prog_select_voltage_i,
  output logic             prog_link_data_o,
  output logic             prog_link_data_oe_o,
  output logic [7:0]       app_rdata_o,
  output logic             app_done_o,
  output logic             app_err_o,
  output logic             flash_busy_o,
  output logic             link_pins_owned_o,
  output logic             lvs_enable_o,
  output logic [7:0]       option_o
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_EXEC, ST_READ, ST_WALK, ST_FINISH
  } state_e;

  state_e      state_reg;
  state_e      state_next;
  logic [7:0]  option_reg;
  logic        icc_mode_reg;
  logic [1:0]  strap_cnt_reg;
  logic        sel_c1_reg;
  logic        sel_c2_reg;
  logic        tool_c1_reg;
  logic        tool_c2_reg;
  logic [1:0]  guard_stage_reg;
  logic        cur_link_reg;
  logic [2:0]  cur_op_reg;
  logic [15:0] cur_addr_reg;
  logic [7:0]  cur_data_reg;
  logic        res_err_reg;
  logic [7:0]  res_data_reg;
  logic [15:0] walk_ptr_reg;
  logic [15:0] walk_end_reg;
  logic        link_pend_reg;
  logic        req_c1_reg;
  logic        req_c2_reg;
  logic        req_c3_reg;
  logic        resp_tgl_reg;
  logic        resp_err_reg;
  logic [7:0]  resp_data_reg;
  logic        full_access;
  logic        allow;
  logic        take_link;
  logic        take_app;
  logic [1:0]  cur_sector;
  logic        mem_we;
  logic [15:0] mem_addr_full;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;

  // Link clock domain state.
  logic                  sel_l1_reg;
  logic                  sel_l2_reg;
  logic [4:0]            rx_cnt_reg;
  logic [25:0]           rx_shift_reg;
  logic [26:0]           frame_reg;
  logic                  req_tgl_reg;
  logic                  link_busy_reg;
  logic                  resp_l1_reg;
  logic                  resp_l2_reg;
  logic                  resp_l3_reg;
  logic [8:0]            tx_shift_reg;
  logic [3:0]            tx_cnt_reg;
  logic                  frame_done;

  // Sector 0 is the top 4K holding the vectors, sector 1 below it.
  function automatic logic [1:0] sector_of(input logic [15:0] a);
    if (a >= flash_pkg::SEC0_BASE) begin
      return 2'h0;
    end else if (a >= flash_pkg::SEC1_BASE) begin
      return 2'h1;
    end
    return 2'h2;
  endfunction

  assign cur_sector  = sector_of(cur_addr_reg);
  assign full_access = tool_c2_reg | icc_mode_reg;
  assign take_link   = (state_reg == ST_IDLE) && link_pend_reg;
  assign take_app    = (state_reg == ST_IDLE) && !link_pend_reg && app_req_i;

  // Pin levels pass two flops before anything looks at them.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_c1_reg  <= 1'b0;
      sel_c2_reg  <= 1'b0;
      tool_c1_reg <= 1'b0;
      tool_c2_reg <= 1'b0;
    end else begin
      sel_c1_reg  <= prog_select_voltage_i;
      sel_c2_reg  <= sel_c1_reg;
      tool_c1_reg <= tool_insert_mode_i;
      tool_c2_reg <= tool_c1_reg;
    end
  end

  // The select pin is caught once after reset release and later changes
  // are ignored until the next reset, so the mode cannot change mid-session.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_cnt_reg <= 2'h0;
      icc_mode_reg  <= 1'b0;
    end else if (strap_cnt_reg != flash_pkg::STRAP_WAIT) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == flash_pkg::STRAP_WAIT - 2'h1) begin
        icc_mode_reg <= sel_c2_reg;
      end
    end
  end

  // Two keys in order open the guard for one program or erase.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      guard_stage_reg <= 2'h0;
    end else if (take_app && app_op_i != flash_pkg::OP_READ) begin
      guard_stage_reg <= 2'h0;
    end else if (app_key_wr_i) begin
      if (guard_stage_reg == 2'h0 && app_key_i == flash_pkg::GUARD_KEY1) begin
        guard_stage_reg <= 2'h1;
      end else if (guard_stage_reg == 2'h1 &&
                   app_key_i == flash_pkg::GUARD_KEY2) begin
        guard_stage_reg <= 2'h2;
      end else begin
        guard_stage_reg <= 2'h0;
      end
    end
  end

  // Link requests arrive by toggle; the frame word is held stable by the
  // link side until the answer returns.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_c1_reg    <= 1'b0;
      req_c2_reg    <= 1'b0;
      req_c3_reg    <= 1'b0;
      link_pend_reg <= 1'b0;
    end else begin
      req_c1_reg <= req_tgl_reg;
      req_c2_reg <= req_c1_reg;
      req_c3_reg <= req_c2_reg;
      if (req_c2_reg ^ req_c3_reg) begin
        link_pend_reg <= 1'b1;
      end else if (take_link) begin
        link_pend_reg <= 1'b0;
      end
    end
  end

  // Permission check on the captured request.
  always_comb begin
    allow = 1'b1;
    if (cur_op_reg != flash_pkg::OP_OPTION &&
        cur_op_reg != flash_pkg::OP_ERASE_ALL &&
        cur_addr_reg < flash_pkg::FLASH_BASE) begin
      allow = 1'b0;
    end
    if (cur_op_reg > flash_pkg::OP_OPTION) begin
      allow = 1'b0;
    end
    if (cur_op_reg != flash_pkg::OP_READ && !full_access &&
        (cur_sector == 2'h0 || cur_op_reg == flash_pkg::OP_ERASE_ALL ||
         cur_op_reg == flash_pkg::OP_OPTION)) begin
      allow = 1'b0;
    end
    if (cur_link_reg && !full_access) begin
      allow = 1'b0;
    end
    if (cur_link_reg && cur_op_reg == flash_pkg::OP_READ &&
        option_reg[flash_pkg::OPT_LOCK_BIT]) begin
      allow = 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (take_link || take_app) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (!allow || cur_op_reg == flash_pkg::OP_PROG) begin
          state_next = ST_FINISH;
        end else if (cur_op_reg == flash_pkg::OP_READ) begin
          state_next = ST_READ;
        end else if (cur_op_reg == flash_pkg::OP_OPTION &&
                     !(option_reg[flash_pkg::OPT_LOCK_BIT] &&
                       !cur_data_reg[flash_pkg::OPT_LOCK_BIT])) begin
          state_next = ST_FINISH;
        end else begin
          state_next = ST_WALK;
        end
      end
      ST_READ: state_next = ST_FINISH;
      ST_WALK: begin
        if (walk_ptr_reg == walk_end_reg) begin
          state_next = ST_FINISH;
        end
      end
      ST_FINISH: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg    <= ST_IDLE;
      flash_busy_o <= 1'b0;
    end else begin
      state_reg    <= state_next;
      flash_busy_o <= (state_next != ST_IDLE);
    end
  end

  // Capture of the request being served; the app guard is checked here.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_link_reg <= 1'b0;
      cur_op_reg   <= flash_pkg::OP_READ;
      cur_addr_reg <= 16'h0000;
      cur_data_reg <= 8'h00;
    end else if (take_link) begin
      cur_link_reg <= 1'b1;
      cur_op_reg   <= frame_reg[flash_pkg::OP_LSB +: 3];
      cur_addr_reg <= frame_reg[flash_pkg::ADDR_LSB +: 16];
      cur_data_reg <= frame_reg[7:0];
    end else if (take_app) begin
      cur_link_reg <= 1'b0;
      // An unguarded app write is turned into an illegal code.
      cur_op_reg   <= (app_op_i == flash_pkg::OP_READ ||
                       guard_stage_reg == 2'h2) ? app_op_i : 3'h7;
      cur_addr_reg <= app_addr_i;
      cur_data_reg <= app_wdata_i;
    end
  end

  // Erase walks write the erased value over one range, a byte per cycle,
  // so neighbouring sectors are never touched.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      walk_ptr_reg <= 16'h0000;
      walk_end_reg <= 16'h0000;
    end else if (state_reg == ST_EXEC) begin
      if (cur_op_reg == flash_pkg::OP_ERASE_SEC) begin
        unique case (cur_sector)
          2'h0: begin
            walk_ptr_reg <= flash_pkg::SEC0_BASE;
            walk_end_reg <= flash_pkg::ADDR_TOP;
          end
          2'h1: begin
            walk_ptr_reg <= flash_pkg::SEC1_BASE;
            walk_end_reg <= flash_pkg::SEC0_BASE - 16'h0001;
          end
          default: begin
            walk_ptr_reg <= flash_pkg::FLASH_BASE;
            walk_end_reg <= flash_pkg::SEC1_BASE - 16'h0001;
          end
        endcase
      end else begin
        walk_ptr_reg <= flash_pkg::FLASH_BASE;
        walk_end_reg <= flash_pkg::ADDR_TOP;
      end
    end else if (state_reg == ST_WALK) begin
      walk_ptr_reg <= walk_ptr_reg + 16'h0001;
    end
  end

  always_comb begin
    mem_we        = 1'b0;
    mem_addr_full = cur_addr_reg;
    mem_wdata     = cur_data_reg;
    if (state_reg == ST_WALK) begin
      mem_we        = 1'b1;
      mem_addr_full = walk_ptr_reg;
      mem_wdata     = flash_pkg::ERASED_BYTE;
    end else if (state_reg == ST_EXEC && allow &&
                 cur_op_reg == flash_pkg::OP_PROG) begin
      mem_we = 1'b1;
    end
  end

  flash_array u_array (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr_full[flash_pkg::MEM_AW-1:0] -
              flash_pkg::FLASH_BASE[flash_pkg::MEM_AW-1:0]),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  // The option byte is written only once the unlock erase has finished;
  // the lock lives in a single bit of it.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      option_reg <= flash_pkg::OPTION_INIT;
    end else if (cur_op_reg == flash_pkg::OP_OPTION && allow &&
                 state_reg != ST_IDLE && state_next == ST_FINISH &&
                 state_reg != ST_READ) begin
      option_reg <= cur_data_reg;
    end
  end

  // Results; an app request during any walk finds the block busy and is refused.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_err_reg  <= 1'b0;
      res_data_reg <= 8'h00;
    end else if (state_reg == ST_EXEC) begin
      res_err_reg  <= !allow;
      res_data_reg <= 8'h00;
    end else if (state_reg == ST_READ) begin
      res_data_reg <= mem_rdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      app_done_o    <= 1'b0;
      app_err_o     <= 1'b0;
      app_rdata_o   <= 8'h00;
      resp_tgl_reg  <= 1'b0;
      resp_err_reg  <= 1'b0;
      resp_data_reg <= 8'h00;
    end else begin
      app_done_o <= 1'b0;
      app_err_o  <= 1'b0;
      if (app_req_i && !take_app) begin
        app_err_o <= 1'b1;
      end else if (state_reg == ST_FINISH && !cur_link_reg) begin
        app_done_o  <= 1'b1;
        app_err_o   <= res_err_reg;
        app_rdata_o <= res_data_reg;
      end
      if (state_reg == ST_FINISH && cur_link_reg) begin
        resp_err_reg  <= res_err_reg;
        resp_data_reg <= res_data_reg;
        resp_tgl_reg  <= ~resp_tgl_reg;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_pins_owned_o <= 1'b0;
      lvs_enable_o      <= 1'b0;
      option_o          <= flash_pkg::OPTION_INIT;
    end else begin
      link_pins_owned_o <= icc_mode_reg;
      lvs_enable_o      <= option_reg[flash_pkg::OPT_LVS_BIT] &
                           ~option_reg[flash_pkg::OPT_LOCK_BIT];
      option_o          <= option_reg;
    end
  end

  // Link clock domain: frames are shifted in MSB first while select is
  // high, then one answer of error bit and data byte is shifted out.
  // The oscillator clock from the tool needs no logic here.
  assign frame_done = sel_l2_reg && !link_busy_reg &&
                      rx_cnt_reg == flash_pkg::FRAME_LAST;

  always_ff @(posedge prog_link_clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_l1_reg   <= 1'b0;
      sel_l2_reg   <= 1'b0;
      rx_cnt_reg   <= 5'h00;
      rx_shift_reg <= 26'h000_0000;
      frame_reg    <= 27'h000_0000;
      req_tgl_reg  <= 1'b0;
    end else begin
      sel_l1_reg <= prog_select_voltage_i;
      sel_l2_reg <= sel_l1_reg;
      if (frame_done) begin
        frame_reg   <= {rx_shift_reg, prog_link_data_i};
        req_tgl_reg <= ~req_tgl_reg;
        rx_cnt_reg  <= 5'h00;
      end else if (sel_l2_reg && !link_busy_reg) begin
        rx_shift_reg <= {rx_shift_reg[24:0], prog_link_data_i};
        rx_cnt_reg   <= rx_cnt_reg + 5'h01;
      end else if (!sel_l2_reg) begin
        rx_cnt_reg <= 5'h00;
      end
    end
  end

  always_ff @(posedge prog_link_clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resp_l1_reg         <= 1'b0;
      resp_l2_reg         <= 1'b0;
      resp_l3_reg         <= 1'b0;
      link_busy_reg       <= 1'b0;
      tx_shift_reg        <= 9'h000;
      tx_cnt_reg          <= 4'h0;
      prog_link_data_o    <= 1'b0;
      prog_link_data_oe_o <= 1'b0;
    end else begin
      resp_l1_reg <= resp_tgl_reg;
      resp_l2_reg <= resp_l1_reg;
      resp_l3_reg <= resp_l2_reg;
      if (frame_done) begin
        link_busy_reg <= 1'b1;
      end else if (resp_l2_reg ^ resp_l3_reg) begin
        tx_shift_reg <= {resp_err_reg, resp_data_reg};
        tx_cnt_reg   <= flash_pkg::RESP_BITS;
      end else if (tx_cnt_reg != 4'h0) begin
        prog_link_data_o    <= tx_shift_reg[8];
        prog_link_data_oe_o <= 1'b1;
        tx_shift_reg        <= {tx_shift_reg[7:0], 1'b0};
        tx_cnt_reg          <= tx_cnt_reg - 4'h1;
      end else if (prog_link_data_oe_o) begin
        prog_link_data_oe_o <= 1'b0;
        link_busy_reg       <= 1'b0;
      end
    end
  end
endmodule

// >>> flash_sector_access_control_assertions.sv
// Port-level checker for the flash access controller.
`timescale 1ns/1ns
module flash_sector_access_control_assertions (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        app_req_i,
  input wire logic [2:0]  app_op_i,
  input wire logic [15:0] app_addr_i,
  input wire logic        tool_insert_mode_i,
  input wire logic        prog_link_clock_i,
  input wire logic        prog_link_data_oe_o,
  input wire logic        app_done_o,
  input wire logic        app_err_o,
  input wire logic        flash_busy_o,
  input wire logic        link_pins_owned_o,
  input wire logic        lvs_enable_o,
  input wire logic [7:0]  option_o
);
  // Link traffic can delay a take, so only app-only sessions are timed.
  sequence s_take;
    app_req_i && !flash_busy_o && !link_pins_owned_o;
  endsequence
  sequence s_app_mode;
    !tool_insert_mode_i && !$past(tool_insert_mode_i, 3);
  endsequence
  property p_read_latency;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_take ##0 (app_op_i == flash_pkg::OP_READ)
    |=> !app_done_o [*3] ##1 app_done_o;
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read answer not on the fourth cycle");
  property p_prog_latency;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_take ##0 (app_op_i == flash_pkg::OP_PROG)
    |=> !app_done_o [*2] ##1 app_done_o;
  endproperty
  a_prog_latency: assert property (p_prog_latency)
    else $error("program answer not on the third cycle");
  property p_busy_refuse;
    @(posedge clk_i) disable iff (!rst_n_i)
    app_req_i && flash_busy_o |=> app_err_o && !app_done_o;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse)
    else $error("request while busy not refused");
  property p_sec0_locked;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_take ##0 s_app_mode ##0 (app_op_i == flash_pkg::OP_PROG &&
      app_addr_i[15:12] == 4'hF)
    |=> !app_done_o [*2] ##1 (app_done_o && app_err_o);
  endproperty
  a_sec0_locked: assert property (p_sec0_locked)
    else $error("sector 0 program not refused in app mode");
  property p_lvs_off;
    @(posedge clk_i) disable iff (!rst_n_i)
    option_o[0] && $stable(option_o) |-> !lvs_enable_o;
  endproperty
  a_lvs_off: assert property (p_lvs_off)
    else $error("supervisor enabled while locked");
  // Link edges seen with the answer drive up; a counter keeps the
  // nine-bit answer check cheap to evaluate.
  logic [3:0] oe_run_reg;
  always_ff @(posedge prog_link_clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_run_reg <= 4'h0;
    end else if (prog_link_data_oe_o) begin
      oe_run_reg <= oe_run_reg + 4'h1;
    end else begin
      oe_run_reg <= 4'h0;
    end
  end
  property p_oe_frame;
    @(posedge prog_link_clock_i) disable iff (!rst_n_i)
    prog_link_data_oe_o ? (oe_run_reg < 4'h9)
                        : (oe_run_reg == 4'h0 || oe_run_reg == 4'h9);
  endproperty
  a_oe_frame: assert property (p_oe_frame)
    else $error("answer drive not nine link cycles");
  property p_owned_sticky;
    @(posedge clk_i) disable iff (!rst_n_i)
    link_pins_owned_o |=> link_pins_owned_o;
  endproperty
  a_owned_sticky: assert property (p_owned_sticky)
    else $error("link pins released during session");
  property p_answer_pulse;
    @(posedge clk_i) disable iff (!rst_n_i)
    app_done_o || app_err_o |=> !app_done_o && !app_err_o;
  endproperty
  a_answer_pulse: assert property (p_answer_pulse)
    else $error("answer stood longer than one cycle");
endmodule

bind flash_sector_access_control flash_sector_access_control_assertions
  flash_sector_access_control_assertions_i (
  .clk_i, .rst_n_i, .app_req_i, .app_op_i, .app_addr_i,
  .tool_insert_mode_i, .prog_link_clock_i, .prog_link_data_oe_o,
  .app_done_o, .app_err_o, .flash_busy_o, .link_pins_owned_o,
  .lvs_enable_o, .option_o
);

// >>> prog_tool_model.sv
// Behavioural programming tool on the serial in-circuit link.
`timescale 1ns/1ns
module prog_tool_model (
  output logic      link_clock_o,
  output logic      tool_data_o,
  output logic      select_o,
  input  wire logic oe_i,
  input  wire logic line_i
);
  initial begin
    link_clock_o = 1'b0;
    tool_data_o = 1'b1;
    select_o = 1'b0;
  end
  task set_select(input logic v);
    select_o = v;
  endtask
  // The clock stands still outside frames, so callers add wake pulses.
  task pulses(input int n);
    repeat (n) begin
      #16 link_clock_o = 1'b1;
      #16 link_clock_o = 1'b0;
    end
  endtask
  task frame(input logic [2:0] op, input logic [15:0] a,
             input logic [7:0] d, output logic [8:0] resp);
    logic [26:0] f;
    int          cnt;
    f = {op, a, d};
    cnt = 0;
    resp = 9'h000;
    #7;
    for (int i = 26; i >= 0; i--) begin
      tool_data_o = f[i];
      pulses(1);
    end
    for (int i = 0; i < 400 && cnt < 9; i++) begin
      tool_data_o = ~tool_data_o;
      pulses(1);
      if (oe_i === 1'b1) begin
        resp = {resp[7:0], line_i};
        cnt++;
      end
    end
    pulses(1);
  endtask
endmodule

// >>> test_flash_sector_access_control.sv
// Self-checking bench for the flash access controller.
`timescale 1ns/1ns
module test_flash_sector_access_control;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        app_req_i = 1'b0;
  logic [2:0]  app_op_i = 3'h0;
  logic [15:0] app_addr_i = 16'h0000;
  logic [7:0]  app_wdata_i = 8'h00;
  logic        app_key_wr_i = 1'b0;
  logic [7:0]  app_key_i = 8'h00;
  logic        tool_insert_mode_i = 1'b0;
  logic        prog_link_clock_i, prog_select_voltage_i, tool_data;
  logic        prog_link_data_o, prog_link_data_oe_o, app_done_o;
  logic        app_err_o, flash_busy_o, link_pins_owned_o, lvs_enable_o;
  logic [7:0]  app_rdata_o, option_o;
  logic [8:0]  resp;
  wire logic   prog_link_data_i;
  int          errors = 0;
  int          checks = 0;
  assign prog_link_data_i = prog_link_data_oe_o ? prog_link_data_o
                                                : tool_data;
  flash_sector_access_control flash_sector_access_control_i (
    .clk_i, .rst_n_i, .app_req_i, .app_op_i, .app_addr_i, .app_wdata_i,
    .app_key_wr_i, .app_key_i, .tool_insert_mode_i, .prog_link_clock_i,
    .prog_link_data_i, .prog_select_voltage_i, .prog_link_data_o,
    .prog_link_data_oe_o, .app_rdata_o, .app_done_o, .app_err_o,
    .flash_busy_o, .link_pins_owned_o, .lvs_enable_o, .option_o);
  prog_tool_model prog_tool_model_i (
    .link_clock_o(prog_link_clock_i), .tool_data_o(tool_data),
    .select_o(prog_select_voltage_i), .oe_i(prog_link_data_oe_o),
    .line_i(prog_link_data_i));
  initial forever #10 clk_i = ~clk_i;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task complete_run;
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task guard;
    @(negedge clk_i);
    app_key_wr_i = 1'b1;
    app_key_i = flash_pkg::GUARD_KEY1;
    @(negedge clk_i);
    app_key_i = flash_pkg::GUARD_KEY2;
    @(negedge clk_i);
    app_key_wr_i = 1'b0;
  endtask
  // With poke set, a second request lands mid-operation and must bounce.
  task app(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d,
           input bit poke, output logic [7:0] rdat, output logic er,
           output int n);
    @(negedge clk_i);
    while (flash_busy_o !== 1'b0) @(negedge clk_i);
    app_op_i = op;
    app_addr_i = a;
    app_wdata_i = d;
    app_req_i = 1'b1;
    @(negedge clk_i);
    app_req_i = 1'b0;
    n = 1;
    while (app_done_o !== 1'b1 && n < 20000) begin
      if (poke) begin
        app_req_i = (n == 8);
        if (n == 9) check(app_err_o, 1'h1);
      end
      @(negedge clk_i);
      n++;
    end
    rdat = app_rdata_o;
    er = app_err_o;
  endtask
  task run(input logic g, input logic [2:0] op, input logic [15:0] a,
           input logic [7:0] d, input logic ee, input logic [31:0] en,
           input bit poke = 0);
    logic [7:0] r;
    logic       er;
    int         n;
    if (g) guard();
    app(op, a, d, poke, r, er, n);
    check(er, ee);
    check(n, en);
  endtask
  task rd_chk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] r;
    logic       er;
    int         n;
    app(flash_pkg::OP_READ, a, 8'h00, 0, r, er, n);
    check(r, e);
    check(n, 32'h4);
  endtask
  task t_app_mode;
    check(option_o, 8'h02);
    check(lvs_enable_o, 1'h1);
    check(link_pins_owned_o, 1'h0);
    run(0, flash_pkg::OP_PROG, 16'hE123, 8'hA5, 1, 32'h3);
    run(1, flash_pkg::OP_PROG, 16'hF000, 8'h11, 1, 32'h3);
    run(1, flash_pkg::OP_ERASE_ALL, 16'hD000, 8'h00, 1, 32'h3);
    run(1, flash_pkg::OP_OPTION, 16'hD000, 8'h03, 1, 32'h3);
    run(1, flash_pkg::OP_PROG, 16'hC000, 8'h22, 1, 32'h3);
    run(1, flash_pkg::OP_PROG, 16'hE123, 8'hA5, 0, 32'h3);
    run(0, flash_pkg::OP_PROG, 16'hE124, 8'hA6, 1, 32'h3);
    run(1, flash_pkg::OP_PROG, 16'hDFFF, 8'h3C, 0, 32'h3);
    run(1, flash_pkg::OP_PROG, 16'hE000, 8'h5A, 0, 32'h3);
    rd_chk(16'hE123, 8'hA5);
    run(1, flash_pkg::OP_ERASE_SEC, 16'hE800, 8'h00, 0, 32'h1003, 1);
    rd_chk(16'hE123, 8'hFF);
    rd_chk(16'hE000, 8'hFF);
    rd_chk(16'hDFFF, 8'h3C);
  endtask
  task t_tool_mode;
    tool_insert_mode_i = 1'b1;
    repeat (4) @(negedge clk_i);
    run(1, flash_pkg::OP_PROG, 16'hF000, 8'h5A, 0, 32'h3);
    rd_chk(16'hF000, 8'h5A);
    run(1, flash_pkg::OP_OPTION, 16'hD000, 8'h03, 0, 32'h3);
    rd_chk(16'hF000, 8'h5A);
    check(option_o, 8'h03);
    check(lvs_enable_o, 1'h0);
    run(1, flash_pkg::OP_OPTION, 16'hD000, 8'h02, 0, 32'h3003, 1);
    rd_chk(16'hF000, 8'hFF);
    rd_chk(16'hDFFF, 8'hFF);
    check(option_o, 8'h02);
    tool_insert_mode_i = 1'b0;
  endtask
  task t_icp_mode;
    @(negedge clk_i);
    rst_n_i = 1'b0;
    prog_tool_model_i.set_select(1'b1);
    prog_tool_model_i.pulses(2);
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    prog_tool_model_i.pulses(2);
    repeat (4) @(negedge clk_i);
    check(link_pins_owned_o, 1'h1);
    run(1, flash_pkg::OP_ERASE_ALL, 16'hD000, 8'h00, 0, 32'h3003);
    run(1, flash_pkg::OP_PROG, 16'hF001, 8'h77, 0, 32'h3);
    prog_tool_model_i.frame(flash_pkg::OP_READ, 16'hF001, 8'h00, resp);
    check(resp, 9'h077);
    run(1, flash_pkg::OP_OPTION, 16'hD000, 8'h03, 0, 32'h3);
    prog_tool_model_i.frame(flash_pkg::OP_READ, 16'hF001, 8'h00, resp);
    check(resp, 9'h100);
    check(link_pins_owned_o, 1'h1);
  endtask
  initial begin
    #1000000;
    errors++;
    complete_run();
  end
  initial begin
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    // Outputs settle on the first edges after release.
    repeat (4) @(negedge clk_i);
    t_app_mode();
    t_tool_mode();
    t_icp_mode();
    complete_run();
  end
endmodule
